// ### core/oet_timer_core.sv
// Function
// - Internal temperature mode: codes 00..11 give 9..12 bits, 3/6/12/24 ms.
// - External mode, external reference: 11/13/14/15 bits, 6/24/50/100 ms.
// - External mode, internal reference: 11/13/14/15 bits, 8/32/64/128 ms.
// - Converter start waits delay field times 10 ms after output control write.
// - Delay loads, decrements each 10 ms; converter enabled only at zero.
// - A valid output control write with nonzero on-count enables the analog output driver.
// - Nonzero on-count decrements each 10 ms, disables output at zero; zero keeps disabled.
// - Output enable timeout equals on-count times 10 ms, up to 2550 ms.
// - When countdown disables the output, a one second hold-off timer starts.
// - Output stays disabled while the controller addresses the device each second.
// - Fault register shows nine comparator outputs in low bits, 1 means fault.
// - Fault order bit 8..0: amp1 hi/lo, amp2 hi/lo, amp3, neg hi/lo, pos hi/lo.
// - Internal temperature select bit: 1 internal sensor, 0 external signal.
// - Reference bit 1 selects internal 2.048 V reference, 0 external reference.
// - Writing 1 to trigger starts one conversion; bit clears when it completes.
// - Continuous bit 1 converts repeatedly, 0 gives noncontinuous operation.
`timescale 1ns/10ps
module oet_timer_core
  import oet_pkg::*;
#(
  parameter int TICK_CYCLES = OET_MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [4:0] regPtr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  output logic regRdValid,
  input wire logic devAddressed,
  input wire logic amp1SatHigh,
  input wire logic amp1SatLow,
  input wire logic amp2SatHigh,
  input wire logic amp2SatLow,
  input wire logic amp3CommonMode,
  input wire logic negInputHigh,
  input wire logic negInputLow,
  input wire logic posInputHigh,
  input wire logic posInputLow,
  output logic voutEnable,
  output logic holdOffActive,
  output logic adcEnable,
  output logic internalTempSelect,
  output logic adcRefInternalSel,
  output logic convBusy,
  output logic convDone,
  output logic [3:0] convBits
);

  oet_tick_if tk ();

  oet_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic wrAdc;
  logic wrOut;
  logic [8:0] faultFlags;

  assign wrAdc = regWrEn && (regPtr == OET_PTR_ADC_CTRL);
  assign wrOut = regWrEn && (regPtr == OET_PTR_OUT_CTRL);

  // Comparator outputs packed in documented order
  assign faultFlags = {amp1SatHigh, amp1SatLow, amp2SatHigh, amp2SatLow, amp3CommonMode,
                       negInputHigh, negInputLow, posInputHigh, posInputLow};

  // ----------------------------------------------------------------
  // Register storage and read port
  // ----------------------------------------------------------------
  logic [15:0] adcCtrl_q;
  logic [15:0] adcCtrl_d;
  logic [15:0] outCtrl_q;
  logic [15:0] outCtrl_d;
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;
  logic rdValid_q;
  logic convClear;

  // Trigger bit: a fresh write of 1 beats the completion clear
  always_comb
  begin
    adcCtrl_d = adcCtrl_q;
    outCtrl_d = outCtrl_q;
    if (convClear)
    begin
      adcCtrl_d[OET_TRIG_BIT] = 1'b0;
    end
    if (wrAdc)
    begin
      adcCtrl_d = regWrData & OET_ADC_CTRL_MASK;
    end
    if (wrOut)
    begin
      // Reserved top bits stored as written; controller keeps them zero
      outCtrl_d = regWrData;
    end
    rdData_d = rdData_q;
    if (regRdEn)
    begin
      unique case (regPtr)
        OET_PTR_ADC_CTRL: rdData_d = adcCtrl_q;
        OET_PTR_OUT_CTRL: rdData_d = outCtrl_q;
        OET_PTR_FAULT: rdData_d = {7'h00, faultFlags};
        default: rdData_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      adcCtrl_q <= OET_ADC_CTRL_RST;
      outCtrl_q <= OET_OUT_CTRL_RST;
      rdData_q <= 16'h0000;
      rdValid_q <= 1'b0;
    end
    else
    begin
      adcCtrl_q <= adcCtrl_d;
      outCtrl_q <= outCtrl_d;
      rdData_q <= rdData_d;
      rdValid_q <= regRdEn;
    end
  end

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;

  // ----------------------------------------------------------------
  // 10 ms step, phase restarted by each output control write
  // ----------------------------------------------------------------
  logic [3:0] stepCnt_q;
  logic [3:0] stepCnt_d;
  logic step10;

  // Restarting the phase keeps the first step between 9 and 10 ms long
  always_comb
  begin
    stepCnt_d = stepCnt_q;
    step10 = 1'b0;
    if (wrOut)
    begin
      stepCnt_d = 4'h0;
    end
    else if (tk.msTick)
    begin
      if (stepCnt_q == OET_STEP_LAST)
      begin
        stepCnt_d = 4'h0;
        step10 = 1'b1;
      end
      else
      begin
        stepCnt_d = stepCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      stepCnt_q <= 4'h0;
    end
    else
    begin
      stepCnt_q <= stepCnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Converter start delay and output enable countdown
  // ----------------------------------------------------------------
  logic [3:0] dlyCnt_q;
  logic [3:0] dlyCnt_d;
  logic adcEn_q;
  logic adcEn_d;
  logic [7:0] onCnt_q;
  logic [7:0] onCnt_d;
  logic vout_q;
  logic vout_d;
  logic [9:0] holdCnt_q;
  logic [9:0] holdCnt_d;
  logic hold_q;
  logic hold_d;

  always_comb
  begin
    dlyCnt_d = dlyCnt_q;
    adcEn_d = adcEn_q;
    onCnt_d = onCnt_q;
    vout_d = vout_q;
    holdCnt_d = holdCnt_q;
    hold_d = hold_q;
    if (wrOut)
    begin
      // Converter held off until the delay count has run out
      dlyCnt_d = regWrData[OET_DELAY_LSB +: 4];
      adcEn_d = 1'b0;
      onCnt_d = regWrData[OET_ON_COUNT_LSB +: 8];
      vout_d = (regWrData[OET_ON_COUNT_LSB +: 8] != 8'h00);
    end
    else
    begin
      if (!adcEn_q)
      begin
        if (dlyCnt_q == 4'h0)
        begin
          adcEn_d = 1'b1;
        end
        else if (step10)
        begin
          dlyCnt_d = dlyCnt_q - 4'h1;
        end
      end
      if (vout_q && step10)
      begin
        onCnt_d = onCnt_q - 8'h01;
        if (onCnt_q == 8'h01)
        begin
          vout_d = 1'b0;
          hold_d = 1'b1;
          holdCnt_d = OET_HOLDOFF_LOAD;
        end
      end
    end
    // Hold-off runs in ms; bus traffic keeps it alive
    if (hold_q && !(vout_q && vout_d == 1'b0))
    begin
      if (devAddressed)
      begin
        holdCnt_d = OET_HOLDOFF_LOAD;
      end
      else if (tk.msTick)
      begin
        if (holdCnt_q == 10'h001)
        begin
          hold_d = 1'b0;
          holdCnt_d = 10'h000;
        end
        else
        begin
          holdCnt_d = holdCnt_q - 10'h001;
        end
      end
    end
    if (wrOut)
    begin
      // A valid write takes the pin back for the output
      hold_d = 1'b0;
      holdCnt_d = 10'h000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      dlyCnt_q <= 4'h0;
      adcEn_q <= 1'b1;
      onCnt_q <= 8'h00;
      vout_q <= 1'b0;
      holdCnt_q <= 10'h000;
      hold_q <= 1'b0;
    end
    else
    begin
      dlyCnt_q <= dlyCnt_d;
      adcEn_q <= adcEn_d;
      onCnt_q <= onCnt_d;
      vout_q <= vout_d;
      holdCnt_q <= holdCnt_d;
      hold_q <= hold_d;
    end
  end

  assign voutEnable = vout_q;
  assign holdOffActive = hold_q;
  assign adcEnable = adcEn_q;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  oet_conv_e conv_q;
  oet_conv_e conv_d;
  logic [7:0] convCnt_q;
  logic [7:0] convCnt_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic done_q;
  logic done_d;
  logic [1:0] resCode;
  logic tempSel;
  logic refInt;
  logic [7:0] convMs;
  logic [3:0] convRes;
  logic wantConv;

  assign resCode = adcCtrl_q[OET_RES_LSB +: 2];
  assign tempSel = adcCtrl_q[OET_TEMP_SEL_BIT];
  assign refInt = adcCtrl_q[OET_REF_INT_BIT];
  assign wantConv = adcCtrl_q[OET_TRIG_BIT] || adcCtrl_q[OET_CONT_BIT];

  // Resolution and conversion time per mode
  always_comb
  begin
    if (tempSel)
    begin
      convMs = OET_CONV_MS_TEMP[resCode];
      convRes = OET_BITS_TEMP[resCode];
    end
    else if (refInt)
    begin
      convMs = OET_CONV_MS_INTREF[resCode];
      convRes = OET_BITS_EXT[resCode];
    end
    else
    begin
      convMs = OET_CONV_MS_EXT[resCode];
      convRes = OET_BITS_EXT[resCode];
    end
  end

  // Settings are latched at start; a new output control write aborts
  always_comb
  begin
    conv_d = conv_q;
    convCnt_d = convCnt_q;
    bits_d = bits_q;
    done_d = 1'b0;
    convClear = 1'b0;
    unique case (conv_q)
      OET_CONV_IDLE:
      begin
        if (adcEn_q && wantConv)
        begin
          conv_d = OET_CONV_RUN;
          convCnt_d = convMs;
          bits_d = convRes;
        end
      end
      OET_CONV_RUN:
      begin
        if (!adcEn_q)
        begin
          conv_d = OET_CONV_IDLE;
        end
        else if (wrAdc && regWrData[OET_TRIG_BIT])
        begin
          convCnt_d = convMs;
          bits_d = convRes;
        end
        else if (tk.msTick)
        begin
          if (convCnt_q == 8'h01)
          begin
            done_d = 1'b1;
            convClear = 1'b1;
            conv_d = OET_CONV_IDLE;
          end
          else
          begin
            convCnt_d = convCnt_q - 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      conv_q <= OET_CONV_IDLE;
      convCnt_q <= 8'h00;
      bits_q <= 4'h0;
      done_q <= 1'b0;
    end
    else
    begin
      conv_q <= conv_d;
      convCnt_q <= convCnt_d;
      bits_q <= bits_d;
      done_q <= done_d;
    end
  end

  assign convBusy = (conv_q == OET_CONV_RUN);
  assign convDone = done_q;
  assign convBits = bits_q;
  assign internalTempSelect = tempSel;
  assign adcRefInternalSel = refInt;

endmodule

// ### core/oet_pkg.sv
package oet_pkg;

  // ----------------------------------------------------------------
  // Register pointers and layout
  // ----------------------------------------------------------------
  localparam logic [4:0] OET_PTR_ADC_CTRL = 5'h06;
  localparam logic [4:0] OET_PTR_OUT_CTRL = 5'h07;
  localparam logic [4:0] OET_PTR_FAULT = 5'h08;
  localparam logic [15:0] OET_ADC_CTRL_RST = 16'h0000;
  localparam logic [15:0] OET_OUT_CTRL_RST = 16'h0000;
  localparam logic [15:0] OET_ADC_CTRL_MASK = 16'h3FFF;

  // Temperature converter control fields
  localparam int OET_RES_LSB = 0;
  localparam int OET_REF_INT_BIT = 8;
  localparam int OET_TEMP_SEL_BIT = 9;
  localparam int OET_CONT_BIT = 10;
  localparam int OET_TRIG_BIT = 12;

  // Output enable control fields and fault register width
  localparam int OET_ON_COUNT_LSB = 0;
  localparam int OET_DELAY_LSB = 8;
  localparam int OET_FAULT_WIDTH = 9;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OET_CLK_PERIOD_NS = 8;
  localparam int OET_MS_NS = 1000000;
  localparam int OET_MS_CYCLES = OET_MS_NS / OET_CLK_PERIOD_NS;
  localparam int OET_STEP_MS = 10;
  localparam int OET_HOLDOFF_MS = 1000;
  localparam logic [3:0] OET_STEP_LAST = 4'(OET_STEP_MS - 1);
  localparam logic [9:0] OET_HOLDOFF_LOAD = 10'(OET_HOLDOFF_MS);

  // Conversion time in ms and magnitude bits, indexed by resolution code
  localparam logic [7:0] OET_CONV_MS_TEMP [4] = '{8'h03, 8'h06, 8'h0C, 8'h18};
  localparam logic [7:0] OET_CONV_MS_EXT [4] = '{8'h06, 8'h18, 8'h32, 8'h64};
  localparam logic [7:0] OET_CONV_MS_INTREF [4] = '{8'h08, 8'h20, 8'h40, 8'h80};
  localparam logic [3:0] OET_BITS_TEMP [4] = '{4'h9, 4'hA, 4'hB, 4'hC};
  localparam logic [3:0] OET_BITS_EXT [4] = '{4'hB, 4'hD, 4'hE, 4'hF};

  typedef enum logic {OET_CONV_IDLE, OET_CONV_RUN} oet_conv_e;

endpackage

// ### core/oet_tick_if.sv
`timescale 1ns/10ps
// Millisecond time base shared between the divider and the timers
interface oet_tick_if;
  logic msTick;
  modport gen (output msTick);
  modport sink (input msTick);
endinterface

// ### core/oet_tick_gen.sv
`timescale 1ns/10ps
module oet_tick_gen
  import oet_pkg::*;
#(
  parameter int TICK_CYCLES = OET_MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  oet_tick_if.gen tk
);

  logic [31:0] divCnt_q;
  logic [31:0] divCnt_d;
  logic tick_q;
  logic tick_d;

  // ----------------------------------------------------------------
  // Free running divider, one pulse per millisecond
  // ----------------------------------------------------------------
  always_comb
  begin
    tick_d = 1'b0;
    divCnt_d = divCnt_q + 32'h00000001;
    if (divCnt_q >= 32'(TICK_CYCLES - 1))
    begin
      divCnt_d = 32'h00000000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      divCnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else
    begin
      divCnt_q <= divCnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.msTick = tick_q;

endmodule

// ### sim/oet_timer_asserts.sv
`timescale 1ns/10ps
module oet_timer_asserts
  import oet_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [4:0] regPtr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  input wire logic regRdValid,
  input wire logic voutEnable,
  input wire logic holdOffActive,
  input wire logic adcEnable,
  input wire logic convBusy,
  input wire logic convDone
);
  // ----------
  // Helpers
  // ----------
  logic outWr;
  logic outWr_q;
  assign outWr = regWrEn && (regPtr == OET_PTR_OUT_CTRL);
  // Tells a countdown expiry apart from a zero load
  always_ff @(posedge clk_sys)
    outWr_q <= outWr;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------
  // Properties
  // ----------
  chk_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  chk_vout_on: assert property (outWr && (regWrData[7:0] != 8'h00) |=> voutEnable)
    else $error("output not enabled");
  chk_vout_zero: assert property (outWr && (regWrData[7:0] == 8'h00) |=> !voutEnable)
    else $error("zero count enabled output");
  chk_adc_hold: assert property (outWr |=> !adcEnable)
    else $error("converter not held");
  chk_adc_nodelay: assert property (outWr && (regWrData[11:8] == 4'h0) |=> !adcEnable ##1 adcEnable)
    else $error("zero delay not honoured");
  chk_holdoff_start: assert property ($fell(voutEnable) && !outWr_q |-> holdOffActive)
    else $error("hold-off not started");
  chk_holdoff_quiet: assert property (holdOffActive |-> !voutEnable)
    else $error("output on during hold-off");
  chk_done_pulse: assert property (convDone |=> !convDone)
    else $error("done longer than one cycle");
  chk_done_busy: assert property (convDone |-> $past(convBusy))
    else $error("done without conversion");
  chk_busy_enabled: assert property ($rose(convBusy) |-> adcEnable)
    else $error("conversion while disabled");
  cov_read: cover property (regRdValid);
  cov_holdoff: cover property ($rose(holdOffActive));
  cov_done: cover property (convDone);
endmodule
bind oet_timer_core oet_timer_asserts chk (.clk_sys, .nrst, .regPtr, .regWrEn, .regWrData, .regRdEn,
  .regRdValid, .voutEnable, .holdOffActive, .adcEnable, .convBusy, .convDone);

// ### sim/oet_ctrl_model.sv
`timescale 1ns/10ps
module oet_ctrl_model
  import oet_pkg::*;
(
  input wire logic clk_sys,
  output logic [4:0] regPtr,
  output logic regWrEn,
  output logic [15:0] regWrData,
  output logic regRdEn,
  output logic devAddressed
);
  // Idle link at time zero
  initial
  begin
    regPtr = 5'h1F;
    regWrEn = 1'b0;
    regWrData = 16'h5A5A;
    regRdEn = 1'b0;
    devAddressed = 1'b0;
  end
  // Released lines are scrambled so stale values never pass
  task automatic wr(input logic [4:0] p, input logic [15:0] d);
    regPtr = p;
    regWrData = (p == OET_PTR_OUT_CTRL) ? {4'h0, d[11:0]} : d;
    regWrEn = 1'b1;
    @(posedge clk_sys);
    #1;
    regWrEn = 1'b0;
    regPtr = ~p;
    regWrData = ~regWrData;
    // Idle edge so a following call never reassigns in this time step
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [4:0] p);
    regPtr = p;
    regRdEn = 1'b1;
    @(posedge clk_sys);
    #1;
    regRdEn = 1'b0;
    regPtr = ~p;
    // Idle edge between back to back reads
    @(posedge clk_sys);
    #1;
  endtask
  // Any link transfer addressing the device
  task automatic ping();
    devAddressed = 1'b1;
    @(posedge clk_sys);
    #1;
    devAddressed = 1'b0;
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
  import oet_pkg::*;
  // ----------
  // Bench setup
  // ----------
  localparam int TK = 4;
  localparam int STEP = TK * 10;
  localparam int HOLD = TK * 1000;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] regPtr;
  logic [15:0] regWrData, regRdData;
  logic regWrEn, regRdEn, devAddressed, regRdValid;
  logic voutEnable, holdOffActive, adcEnable, tempSel, refSel, convBusy, convDone;
  logic [3:0] convBits;
  logic [8:0] flt = 9'h000;
  logic [31:0] lfsr = 32'h22BDC311;
  logic [15:0] expQ[$];
  int errCount = 0;
  int nTests = 0;
  int msTab[3][4] = '{'{3, 6, 12, 24}, '{6, 24, 50, 100}, '{8, 32, 64, 128}};
  logic [3:0] bitTab[2][4] = '{'{4'h9, 4'hA, 4'hB, 4'hC}, '{4'hB, 4'hD, 4'hE, 4'hF}};
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  // Short ms tick keeps the one-second hold-off affordable
  oet_timer_core #(.TICK_CYCLES(TK)) dut (.clk_sys, .nrst, .regPtr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .regRdValid, .devAddressed, .amp1SatHigh(flt[8]), .amp1SatLow(flt[7]),
    .amp2SatHigh(flt[6]), .amp2SatLow(flt[5]), .amp3CommonMode(flt[4]), .negInputHigh(flt[3]),
    .negInputLow(flt[2]), .posInputHigh(flt[1]), .posInputLow(flt[0]), .voutEnable, .holdOffActive,
    .adcEnable, .internalTempSelect(tempSel), .adcRefInternalSel(refSel), .convBusy, .convDone, .convBits);
  oet_ctrl_model ctl (.clk_sys, .regPtr, .regWrEn, .regWrData, .regRdEn, .devAddressed);
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] nextLfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: return voutEnable;
      1: return adcEnable;
      2: return holdOffActive;
      default: return convDone;
    endcase
  endfunction
  task automatic testDone();
    $display("Comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmpData(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    cmpData({15'h0000, got}, {15'h0000, exp});
  endtask
  // Tick phase is free, so allow one tick plus pipeline either way
  task automatic cmpTime(input int got, input int exp);
    nTests++;
    if (got < exp - TK - 3 || got > exp + TK + 3)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic waitFor(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      step();
      n++;
    end
    if (n >= lim)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, s, v);
      testDone();
    end
  endtask
  task automatic rdChk(input logic [4:0] p, input logic [15:0] e);
    expQ.push_back(e);
    ctl.rd(p);
  endtask
  // Pair each read answer with the oldest expectation
  always @(posedge clk_sys)
    if (regRdValid === 1'b1)
      cmpData(regRdData, (expQ.size() > 0) ? expQ.pop_front() : 16'hDEAD);
  // ----------
  // Scenarios
  // ----------
  initial
  begin
    int n;
    int t;
    logic [3:0] dly;
    logic [7:0] on;
    logic [15:0] w;
    repeat (12) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    rdChk(OET_PTR_OUT_CTRL, 16'h0000);
    rdChk(OET_PTR_ADC_CTRL, 16'h0000);
    rdChk(5'h1F, 16'h0000);
    ctl.wr(OET_PTR_FAULT, 16'hFFFF);
    repeat (4)
    begin
      lfsr = nextLfsr(lfsr);
      flt = lfsr[8:0];
      rdChk(OET_PTR_FAULT, {7'h00, flt});
    end
    // Random counts, then the largest on-count
    for (int k = 0; k < 3; k++)
    begin
      lfsr = nextLfsr(lfsr);
      dly = (k == 2) ? 4'h0 : {2'b00, lfsr[1:0]};
      on = (k == 2) ? 8'hFF : 8'(dly) + 8'(lfsr[4:2]) + 8'h01;
      w = {4'h0, dly, on};
      ctl.wr(OET_PTR_OUT_CTRL, w);
      cmpBit(voutEnable, 1'b1);
      rdChk(OET_PTR_OUT_CTRL, w);
      waitFor(1, 1'b1, 700, n);
      cmpTime(n, int'(dly) * STEP);
      waitFor(0, 1'b0, 11000, t);
      cmpTime(n + t, int'(on) * STEP);
      cmpBit(holdOffActive, 1'b1);
      repeat (2)
      begin
        repeat (HOLD - 900) @(posedge clk_sys);
        #1;
        ctl.ping();
        cmpBit(holdOffActive, 1'b1);
      end
      cmpBit(voutEnable, 1'b0);
      waitFor(2, 1'b0, HOLD + 50, n);
      cmpTime(n, HOLD);
    end
    ctl.wr(OET_PTR_OUT_CTRL, 16'h0300);
    step();
    cmpBit(voutEnable, 1'b0);
    waitFor(1, 1'b1, 200, n);
    // Every mode and resolution code
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 4; c++)
      begin
        w = 16'h1000 | ((m == 0) ? 16'h0200 : (m == 2) ? 16'h0100 : 16'h0000) | 16'(c);
        ctl.wr(OET_PTR_ADC_CTRL, w);
        cmpBit(convBusy, 1'b1);
        waitFor(3, 1'b1, 600, n);
        cmpBit(convBusy, 1'b0);
        cmpTime(n, msTab[m][c] * TK);
        cmpData({12'h000, convBits}, {12'h000, bitTab[(m == 0) ? 0 : 1][c]});
        cmpBit(tempSel, m == 0);
        cmpBit(refSel, m == 2);
        rdChk(OET_PTR_ADC_CTRL, w & 16'hEFFF);
      end
    ctl.wr(OET_PTR_ADC_CTRL, 16'h0600);
    waitFor(3, 1'b1, 100, n);
    step();
    waitFor(3, 1'b1, 100, n);
    cmpTime(n, 3 * TK);
    ctl.wr(OET_PTR_ADC_CTRL, 16'h0000);
    testDone();
  end
endmodule
